// >>> hdl/idb_defs.svh
// Constants for the interleaved DRAM burst count and ready block.
// Assumes inclusion by bare name from the package and the design file.
`ifndef IDB_DEFS_SVH
`define IDB_DEFS_SVH

// Bank counter width, LSB included
`define IDB_CNT_W 8
// Bus word width carried through the read FIFO
`define IDB_WORD_W 32
// Read FIFO depth in words
`define IDB_FIFO_DEPTH 32
// Reset value of the even bank counter; the odd counter resets to it with the LSB inverted
`define IDB_CNT_RST 8'h00
// Position of the bank-select LSB in a counter
`define IDB_LSB 0
// Reset value of single-bit state flags
`define IDB_BIT_RST 1'h0

`endif

// >>> hdl/idb_pkg.sv
// Types shared by the interleaved DRAM burst count and ready block.
// Assumes idb_defs.svh is on the include path.
`include "idb_defs.svh"

package idb_pkg;
  // One bank address counter, LSB is the phase bit
  typedef logic [`IDB_CNT_W-1:0] idb_cnt_t;
  // One word on the instruction bus
  typedef logic [`IDB_WORD_W-1:0] idb_word_t;
  // Initial-access phase, Gray coded along the path
  typedef enum logic [1:0] {
    IDB_IDLE = 2'h0,
    IDB_ROW = 2'h1,
    IDB_COL = 2'h3,
    IDB_LAST = 2'h2
  } idb_phase_t;
endpackage : idb_pkg

// >>> hdl/idb_burst_ready.sv
// Burst counters, ready and bank drive logic for a two-bank interleaved DRAM.
// Assumes all processor and controller inputs are synchronous to i_clock.
//
// Overview of operation
// RULE1: Upper bits advance on count with LSB; not on invalid bus.
// RULE2: The two bank LSBs always differ. The code inverts the odd LSB at load and reset only; the LSBs match once counting starts.
// RULE3: Even bank starts counting one cycle before odd.
// RULE4: Count increments its counter at next clock edge.
// RULE5: Even count first asserts in first column-state cycle.
// RULE6: Even start address: first count sets only LSB.
// RULE7: Odd start address: first count advances whole even counter.
// RULE8: Second cycle counts again; later counts need burst request.
// RULE9: Precharge blocks increments so loaded address survives.
// RULE10: Write third-cycle even count needs prior burst request.
// RULE11: Odd count matches even, first count one later.
// RULE12: Instruction ready always in third initial cycle. The code also requires the read FIFO not to be full.
// RULE13: Burst ready needs prior request, ack, valid bus.
// RULE14: Delayed ack qualifies ready against preempted requests.
// RULE15: Register burst request; ready combinational from it.
// RULE16: Bank drive enables follow ready and even LSB.
// RULE17: Data ready like instruction; writes one cycle early.
// RULE18: Delayed ack is ack registered one cycle.
// RULE19: Precharge two cycles: flag one, then flag two.
// RULE20: Init state one lasts three cycles; two, three follow.
// RULE21: Reset clears state bits, flags and delayed registers.
`timescale 1ns/100ps
`default_nettype none
`include "idb_defs.svh"

// Plain synchronous FIFO with valid/ready on both sides
module idb_fifo #(
  parameter int WIDTH = `IDB_WORD_W,
  parameter int DEPTH = `IDB_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];     // Word storage
  logic [AW-1:0] wr_q, wr_d;         // Write pointer
  logic [AW-1:0] rd_q, rd_d;         // Read pointer
  logic [AW:0] cnt_q, cnt_d;         // Fill level
  logic push, pop;

  // Pointer and level update, full and empty from the level only
  always_comb begin
    push = i_valid && (cnt_q != (AW+1)'(DEPTH));
    pop = i_ready && (cnt_q != '0);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; contents are gated by the level
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_q] <= i_data;
    end
  end

  assign o_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data = mem[rd_q];
endmodule : idb_fifo

module idb_burst_ready (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Access sequencing from the controller
  input wire logic i_instr_start,
  input wire logic i_data_start,
  input wire logic i_precharge_start,
  input wire logic i_load,
  input wire logic [`IDB_CNT_W-1:0] i_load_addr,
  // Processor bus terms
  input wire logic i_bus_invalid,
  input wire logic i_instr_burst_request,
  input wire logic i_data_burst_request,
  input wire logic i_instr_burst_ack,
  input wire logic i_data_burst_ack,
  input wire logic i_data_access_active_internal,
  input wire logic i_data_read,
  // Memory read word and drain side of the read FIFO
  input wire logic [`IDB_WORD_W-1:0] i_instr_word,
  input wire logic i_fifo_ready,
  // Bank addresses and phase
  output logic [`IDB_CNT_W-2:0] o_even_addr,
  output logic [`IDB_CNT_W-2:0] o_odd_addr,
  output logic o_even_counter_lsb,
  // Ready and drive enables
  output logic o_instr_ready_out,
  output logic o_data_ready_out,
  output logic o_even_bank_instr_drive,
  output logic o_odd_bank_instr_drive,
  // State flags
  output logic o_instr_init_state_3,
  output logic o_data_init_state_3,
  output logic o_precharge_flag_1,
  output logic o_precharge_flag_2,
  // Read FIFO drain
  output logic o_fifo_valid,
  output logic [`IDB_WORD_W-1:0] o_fifo_word
);
  idb_pkg::idb_cnt_t even_q, even_d;     // Even bank counter
  idb_pkg::idb_cnt_t odd_q, odd_d;       // Odd bank counter
  idb_pkg::idb_phase_t iph_q, iph_d;     // Instruction initial phase
  idb_pkg::idb_phase_t dph_q, dph_d;     // Data initial phase
  logic pc1_q, pc1_d, pc2_q, pc2_d;      // Precharge flags
  logic instr_burst_request_q, data_burst_request_q;                // Registered burst requests
  logic instr_burst_ack_q, data_burst_ack_q;                // Delayed burst acks
  logic bus_invalid_q;                          // Bus invalid, delayed
  logic iq1, iq2, iq3, dq1, dq2, dq3;    // Decoded init state bits
  logic even_count, odd_count;           // Bank count strobes
  logic instr_ready_out, data_ready_out; // Ready terms
  logic fifo_in_ready;                   // Back-pressure from the FIFO
  logic ib, db1, rw;

  // Burst term shared by counts, readies and drive enables
  function automatic logic burst_ok(input logic q1, input logic p1,
                                    input logic p2, input logic req_d);
    burst_ok = !q1 && !p1 && !p2 && req_d; // [RULE9] [RULE8]
  endfunction : burst_ok

  // Ready term for bursts, qualified by the delayed ack
  function automatic logic burst_rdy(input logic q1, input logic req_d,
                                     input logic ack_d);
    burst_rdy = !bus_invalid_q && burst_ok(q1, pc1_q, pc2_q, req_d) && ack_d; // [RULE13] [RULE14]
  endfunction : burst_rdy

  // Phase decode: state 1 spans three cycles, 2 the last two, 3 the last
  always_comb begin
    iq1 = (iph_q != idb_pkg::IDB_IDLE); // [RULE20]
    iq2 = (iph_q == idb_pkg::IDB_COL) || (iph_q == idb_pkg::IDB_LAST);
    iq3 = (iph_q == idb_pkg::IDB_LAST);
    dq1 = (dph_q != idb_pkg::IDB_IDLE);
    dq2 = (dph_q == idb_pkg::IDB_COL) || (dph_q == idb_pkg::IDB_LAST);
    dq3 = (dph_q == idb_pkg::IDB_LAST);
  end

  // Next phase and precharge flags
  always_comb begin
    case (iph_q)
      idb_pkg::IDB_IDLE: iph_d = i_instr_start ? idb_pkg::IDB_ROW : idb_pkg::IDB_IDLE;
      idb_pkg::IDB_ROW: iph_d = idb_pkg::IDB_COL;
      idb_pkg::IDB_COL: iph_d = idb_pkg::IDB_LAST;
      default: iph_d = idb_pkg::IDB_IDLE;
    endcase
    case (dph_q)
      idb_pkg::IDB_IDLE: dph_d = i_data_start ? idb_pkg::IDB_ROW : idb_pkg::IDB_IDLE;
      idb_pkg::IDB_ROW: dph_d = idb_pkg::IDB_COL;
      idb_pkg::IDB_COL: dph_d = idb_pkg::IDB_LAST;
      default: dph_d = idb_pkg::IDB_IDLE;
    endcase
    pc1_d = i_precharge_start && !pc1_q; // [RULE19]
    pc2_d = pc1_q && !pc2_q;             // [RULE19]
  end

  // Count strobes; a full FIFO or an invalid bus holds both counters
  always_comb begin
    ib = i_instr_burst_ack;
    db1 = i_data_access_active_internal;
    rw = i_data_read;
    even_count = (ib && iq2) // [RULE5] [RULE8]
      || (ib && burst_ok(iq1, pc1_q, pc2_q, instr_burst_request_q))
      || (db1 && rw && dq2)
      || (db1 && rw && burst_ok(dq1, pc1_q, pc2_q, data_burst_request_q))
      || (db1 && !rw && dq2 && !dq3)
      || (db1 && !rw && dq3 && data_burst_request_q) // [RULE10]
      || (db1 && !rw && burst_ok(dq1, pc1_q, pc2_q, data_burst_request_q));
    odd_count = (ib && iq3) // [RULE11] [RULE3]
      || (ib && burst_ok(iq1, pc1_q, pc2_q, instr_burst_request_q))
      || (db1 && rw && dq3)
      || (db1 && rw && burst_ok(dq1, pc1_q, pc2_q, data_burst_request_q))
      || (db1 && !rw && dq3 && data_burst_request_q)
      || (db1 && !rw && burst_ok(dq1, pc1_q, pc2_q, data_burst_request_q));
    even_count = even_count && !i_bus_invalid && fifo_in_ready; // [RULE1]
    odd_count = odd_count && !i_bus_invalid && fifo_in_ready;   // [RULE1]
  end

  // Counter next values; odd LSB loads inverted so phases differ
  always_comb begin
    even_d = even_q;
    odd_d = odd_q;
    if (i_load) begin
      even_d = i_load_addr;
      odd_d = i_load_addr ^ `IDB_CNT_W'(1); // [RULE2]
    end else begin
      // Whole-word +1: LSB low sets LSB only, LSB high carries upward
      if (even_count) begin
        even_d = even_q + `IDB_CNT_W'(1); // [RULE4] [RULE6] [RULE7] [RULE1]
      end
      if (odd_count) begin
        odd_d = odd_q + `IDB_CNT_W'(1); // [RULE4] [RULE1]
      end
    end
  end

  // Ready terms; combinational by necessity from registered inputs and, for data ready, i_data_read
  always_comb begin
    instr_ready_out = (iq3 || burst_rdy(iq1, instr_burst_request_q, instr_burst_ack_q)) // [RULE12] [RULE13]
      && fifo_in_ready;
    data_ready_out = (rw && dq3) // [RULE17]
      || (rw && burst_rdy(dq1, data_burst_request_q, data_burst_ack_q))
      || (!rw && dq2 && !dq3)
      || (!rw && dq3 && !bus_invalid_q && data_burst_request_q && data_burst_ack_q)
      || (!rw && burst_rdy(dq1, data_burst_request_q, data_burst_ack_q));
  end

  // All state registers; reset leaves no count or ready active
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      even_q <= `IDB_CNT_RST;
      odd_q <= `IDB_CNT_RST ^ `IDB_CNT_W'(1);
      iph_q <= idb_pkg::IDB_IDLE; // [RULE21]
      dph_q <= idb_pkg::IDB_IDLE;
      pc1_q <= `IDB_BIT_RST;
      pc2_q <= `IDB_BIT_RST;
      instr_burst_request_q <= `IDB_BIT_RST;
      data_burst_request_q <= `IDB_BIT_RST;
      instr_burst_ack_q <= `IDB_BIT_RST;
      data_burst_ack_q <= `IDB_BIT_RST;
      bus_invalid_q <= `IDB_BIT_RST;
    end else begin
      even_q <= even_d;
      odd_q <= odd_d;
      iph_q <= iph_d;
      dph_q <= dph_d;
      pc1_q <= pc1_d;
      pc2_q <= pc2_d;
      instr_burst_request_q <= i_instr_burst_request; // [RULE15]
      data_burst_request_q <= i_data_burst_request;
      instr_burst_ack_q <= i_instr_burst_ack;     // [RULE18]
      data_burst_ack_q <= i_data_burst_ack;      // [RULE18]
      bus_invalid_q <= i_bus_invalid;
    end
  end

  // Read words enter the FIFO on each instruction ready
  idb_fifo #(
    .WIDTH(`IDB_WORD_W),
    .DEPTH(`IDB_FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_valid(instr_ready_out),
    .i_data(i_instr_word),
    .o_ready(fifo_in_ready),
    .o_valid(o_fifo_valid),
    .o_data(o_fifo_word),
    .i_ready(i_fifo_ready)
  );

  // Outputs
  assign o_even_addr = even_q[`IDB_CNT_W-1:1];
  assign o_odd_addr = odd_q[`IDB_CNT_W-1:1];
  assign o_even_counter_lsb = even_q[`IDB_LSB];
  assign o_instr_ready_out = instr_ready_out;
  assign o_data_ready_out = data_ready_out;
  assign o_even_bank_instr_drive = instr_ready_out && even_q[`IDB_LSB];  // [RULE16]
  assign o_odd_bank_instr_drive = instr_ready_out && !even_q[`IDB_LSB]; // [RULE16]
  assign o_instr_init_state_3 = iq3;
  assign o_data_init_state_3 = dq3;
  assign o_precharge_flag_1 = pc1_q;
  assign o_precharge_flag_2 = pc2_q;

  // Checks
  sequence s_init_walk;
    !iq1 ##1 iq1 && !iq2 ##1 iq2 && !iq3 ##1 iq3 ##1 !iq1;
  endsequence
  sequence s_pc_walk;
    pc1_q && !pc2_q ##1 !pc1_q && pc2_q;
  endsequence

  a_lsb_phase_differs: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE2]
    $past(i_load) |-> even_q[`IDB_LSB] != odd_q[`IDB_LSB])
    else $error("bank LSBs equal after load");
  a_upper_step: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE1]
    (even_count && !i_load && even_q[`IDB_LSB]) |=>
      o_even_addr == $past(o_even_addr) + 1'b1)
    else $error("even upper bits failed to step");
  a_upper_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE6]
    (!i_load && !even_q[`IDB_LSB]) |=> o_even_addr == $past(o_even_addr))
    else $error("even upper bits moved with LSB low");
  a_no_count_invalid: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE1]
    (i_bus_invalid && !i_load) |=> even_q == $past(even_q) && odd_q == $past(odd_q))
    else $error("counter moved on invalid bus");
  a_init_sequence: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE20]
    (!iq1 && i_instr_start) |-> s_init_walk)
    else $error("instruction init states out of order");
  a_precharge_pair: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE19]
    (!pc1_q && i_precharge_start) |=> s_pc_walk)
    else $error("precharge flags out of order");
  a_ready_third: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE12]
    (!iq1 && i_instr_start ##3 fifo_in_ready) |-> o_instr_ready_out)
    else $error("no instruction ready in third init cycle");
  a_ready_needs_ack: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE14]
    (o_instr_ready_out && !iq3) |-> $past(i_instr_burst_ack)
      && $past(i_instr_burst_request) && !$past(i_bus_invalid))
    else $error("burst ready without prior ack and request");
  a_drive_exclusive: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE16]
    o_instr_ready_out |-> (o_even_bank_instr_drive ^ o_odd_bank_instr_drive))
    else $error("bank drive enables not exclusive");
  a_no_pc_count: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE9]
    (pc1_q || pc2_q) && !iq1 && !dq1 |-> !even_count && !odd_count)
    else $error("count during precharge");
  a_write_early: assert property (@(posedge i_clock) disable iff (!i_rst_n) // [RULE17]
    (!rw && dq2 && !dq3) |-> o_data_ready_out)
    else $error("write ready not one cycle early");
endmodule : idb_burst_ready

`default_nettype wire

// >>> verif/idb_proc_model.sv
// Processor-side model: instruction burst request and FIFO drain.
// Assumes the bench changes its controls just after a falling edge.
`timescale 1ns/100ps
`default_nettype none

module idb_proc_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Bench controls
  input wire logic i_want_burst,
  input wire logic i_want_drain,
  // FIFO drain side
  input wire logic i_fifo_valid,
  input wire logic [31:0] i_fifo_word,
  output logic o_instr_burst_request,
  output logic o_fifo_ready
);
  // Words taken from the FIFO, oldest first
  idb_pkg::idb_word_t got[$];

  // Request moves late in the cycle, so the block must register it
  assign o_instr_burst_request = i_want_burst & i_rst_n;
  // Drain side stalls whenever the bench says so
  assign o_fifo_ready = i_want_drain & i_rst_n;

  // Capture every accepted word
  always @(posedge i_clock) begin
    if (o_fifo_ready && i_fifo_valid === 1'b1) begin
      got.push_back(i_fifo_word);
    end
  end
endmodule : idb_proc_model

`default_nettype wire

// >>> verif/idb_burst_ready_tb_top.sv
// Self-checking bench for the burst count and ready block.
// Assumes idb_pkg is compiled first; inputs move at the falling edge.
`timescale 1ns/100ps
`default_nettype none

module idb_burst_ready_tb_top;
  // Stimulus towards the block
  logic i_clock, i_rst_n, i_instr_start, i_data_start, i_precharge_start;
  logic i_load, i_bus_invalid, i_data_burst_request, i_instr_burst_ack;
  logic i_data_burst_ack, i_data_access_active_internal, i_data_read;
  logic want_burst, want_drain;
  idb_pkg::idb_cnt_t i_load_addr;
  idb_pkg::idb_word_t i_instr_word, o_fifo_word;
  wire logic i_instr_burst_request, i_fifo_ready;
  // Observed outputs
  logic [6:0] o_even_addr, o_odd_addr;
  logic o_even_counter_lsb, o_instr_ready_out, o_data_ready_out;
  logic o_even_bank_instr_drive, o_odd_bank_instr_drive, o_instr_init_state_3;
  logic o_data_init_state_3, o_precharge_flag_1, o_precharge_flag_2, o_fifo_valid;
  // Scoreboard
  int errors, cmp_count;
  idb_pkg::idb_word_t exp_q[$];

  idb_burst_ready dut_u (.i_clock, .i_rst_n, .i_instr_start, .i_data_start,
    .i_precharge_start, .i_load, .i_load_addr, .i_bus_invalid,
    .i_instr_burst_request, .i_data_burst_request, .i_instr_burst_ack,
    .i_data_burst_ack, .i_data_access_active_internal, .i_data_read,
    .i_instr_word, .i_fifo_ready, .o_even_addr, .o_odd_addr,
    .o_even_counter_lsb, .o_instr_ready_out, .o_data_ready_out,
    .o_even_bank_instr_drive, .o_odd_bank_instr_drive, .o_instr_init_state_3,
    .o_data_init_state_3, .o_precharge_flag_1, .o_precharge_flag_2,
    .o_fifo_valid, .o_fifo_word);
  idb_proc_model proc_u (.i_clock, .i_rst_n, .i_want_burst(want_burst),
    .i_want_drain(want_drain), .i_fifo_valid(o_fifo_valid),
    .i_fifo_word(o_fifo_word), .o_instr_burst_request(i_instr_burst_request),
    .o_fifo_ready(i_fifo_ready));

  // 10 MHz clock
  always #50 i_clock = ~i_clock;
  // Fresh memory word every cycle
  always @(negedge i_clock) i_instr_word <= i_instr_word + 32'h1;
  // Each ready pushes the word on the bus into the FIFO
  always @(posedge i_clock) begin
    if (o_instr_ready_out === 1'b1) exp_q.push_back(i_instr_word);
  end

  task automatic cyc(input int n = 1);
    repeat (n) @(negedge i_clock);
  endtask : cyc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Nothing may be active out of reset
  task automatic t_idle;
    chk({o_instr_ready_out, o_data_ready_out, o_even_bank_instr_drive,
      o_odd_bank_instr_drive, o_instr_init_state_3, o_data_init_state_3,
      o_precharge_flag_1, o_precharge_flag_2, o_fifo_valid}, 0, "idle");
    $display("idle check done");
  endtask : t_idle

  // Initial access from address a, then a burst of n words and a preempt
  task automatic t_instr(input idb_pkg::idb_cnt_t a, input int n);
    idb_pkg::idb_cnt_t e;
    idb_pkg::idb_cnt_t od;
    cyc();
    {i_load, i_instr_start, i_instr_burst_ack, want_burst} = 4'hf;
    i_load_addr = a;
    cyc();
    {i_load, i_instr_start} = 2'h0;
    cyc(); #1;
    chk(o_instr_ready_out, 0, "early ready");
    cyc(); #1;
    e = a + 8'h01;
    od = a ^ 8'h01;
    chk({o_instr_init_state_3, o_instr_ready_out}, 2'h3, "third");
    chk({o_even_addr, o_even_counter_lsb}, e, "first count");
    chk(o_odd_addr, od[7:1], "odd first");
    chk({o_even_bank_instr_drive, o_odd_bank_instr_drive}, {e[0], ~e[0]}, "bank");
    repeat (n) begin
      cyc(); #1;
      e = e + 8'h01;
      chk(o_instr_ready_out, 1, "burst ready");
      chk({o_even_addr, o_even_counter_lsb}, e, "burst count");
      od = od + 8'h01;
      chk(o_odd_addr, od[7:1], "odd burst");
      chk({o_even_bank_instr_drive, o_odd_bank_instr_drive}, {e[0], ~e[0]}, "bank");
    end
    cyc();
    i_bus_invalid = 1;
    e = e + 8'h01;
    cyc();
    {i_bus_invalid, i_instr_burst_ack} = 2'h0;
    #1;
    chk({o_instr_ready_out, o_even_addr, o_even_counter_lsb}, {1'b0, e}, "invalid");
    cyc(); #1;
    chk(o_instr_ready_out, 0, "preempted");
    want_burst = 0;
    cyc(2);
    $display("instr access from %h done", a);
  endtask : t_instr

  // Precharge holds a freshly loaded address
  task automatic t_prech;
    cyc();
    {i_load, i_precharge_start, i_instr_burst_ack, want_burst} = 4'hf;
    i_load_addr = 8'h10;
    cyc();
    {i_load, i_precharge_start} = 2'h0;
    for (int i = 0; i < 3; i++) begin
      #1;
      chk({o_precharge_flag_1, o_precharge_flag_2}, 2'h2 >> i, "flags");
      chk({o_even_addr, o_even_counter_lsb}, 8'h10, "held");
      chk(o_instr_ready_out, i == 2, "ready");
      cyc();
    end
    #1;
    chk({o_even_addr, o_even_counter_lsb}, 8'h11, "resume");
    {want_burst, i_instr_burst_ack} = 2'h0;
    $display("precharge done");
  endtask : t_prech

  // Data write is ready one cycle before data read; bursts need a request
  task automatic t_data;
    idb_pkg::idb_cnt_t b;
    idb_pkg::idb_cnt_t e;
    logic rw, brq;
    for (int k = 0; k < 4; k++) begin
      {brq, rw} = k[1:0];
      cyc();
      {i_data_start, i_data_access_active_internal, i_data_burst_ack} = 3'h7;
      {i_data_burst_request, i_data_read} = {brq, rw};
      cyc();
      i_data_start = 0;
      #1;
      b = {o_even_addr, o_even_counter_lsb};
      chk(o_data_ready_out, 0, "d1");
      cyc(); #1;
      chk(o_data_ready_out, !rw, "d2");
      cyc(); #1;
      chk({o_data_init_state_3, o_data_ready_out}, {1'b1, rw | brq}, "d3");
      e = b + 8'h01;
      chk({o_even_addr, o_even_counter_lsb}, e, "d3 count");
      cyc(); #1;
      chk(o_data_ready_out, brq, "d4");
      e = e + {7'h00, rw | brq};
      chk({o_even_addr, o_even_counter_lsb}, e, "d4 count");
      cyc();
      {i_data_access_active_internal, i_data_burst_ack, i_data_burst_request} = 3'h0;
    end
    $display("data access done");
  endtask : t_data

  // Fill the FIFO with the drain stalled, then empty it
  task automatic t_fifo;
    cyc(40);
    want_drain = 0;
    exp_q.delete();
    proc_u.got.delete();
    cyc();
    {i_load, i_instr_start, i_instr_burst_ack, want_burst} = 4'hf;
    i_load_addr = 8'h00;
    cyc();
    {i_load, i_instr_start} = 2'h0;
    cyc(45); #1;
    chk(exp_q.size(), 32, "fill");
    chk(o_instr_ready_out, 0, "full");
    {want_burst, i_instr_burst_ack} = 2'h0;
    want_drain = 1;
    cyc(45);
    chk(proc_u.got.size(), 32, "drain");
    foreach (proc_u.got[i]) chk(proc_u.got[i], exp_q[i], "word");
    chk(o_fifo_valid, 0, "empty");
    $display("fifo done");
  endtask : t_fifo

  // Hang guard, well past the expected run length
  initial begin
    #400000;
    errors++;
    $display("BAD t=%0t watchdog", $time);
    final_report();
  end

  initial begin
    {i_clock, i_rst_n, i_instr_start, i_data_start, i_precharge_start} = 5'h0;
    {i_load, i_bus_invalid, i_data_burst_request, i_instr_burst_ack} = 4'h0;
    {i_data_burst_ack, i_data_access_active_internal, i_data_read} = 3'h0;
    {want_burst, want_drain} = 2'h1;
    i_load_addr = 8'h00;
    i_instr_word = 32'h0;
    errors = 0;
    cmp_count = 0;
    repeat (20) @(posedge i_clock);
    #1 t_idle();
    @(negedge i_clock) i_rst_n = 1;
    cyc(); #1;
    t_idle();
    t_instr(8'h00, 5);
    t_instr(8'h03, 6);
    t_prech();
    t_data();
    t_fifo();
    final_report();
  end
endmodule : idb_burst_ready_tb_top

`default_nettype wire
